// >>> inc/pts_cfg.svh
`ifndef PTS_CFG_SVH
`define PTS_CFG_SVH
// step command field values
`define PTS_CMD_CTRL 4'h0
`define PTS_CMD_ADDCOPY 4'h1
`define PTS_OPT_SD_OFF 4'h2
`define PTS_OPT_SD_ON 4'h6
`define PTS_OPT_WAIT_T0 4'h8
`define PTS_OPT_WAIT_T1 4'h9
`define PTS_OPT_WAIT_SW 4'hB
`define PTS_OPT_ADC_C0 4'hC
`define PTS_OPT_ADC_C1 4'hD
`define PTS_OPT_ADC_L0 4'hE
`define PTS_OPT_BCAST 4'hF
// limit slots, also add/copy destination codes
`define PTS_LIM_C0 3'h0
`define PTS_LIM_C1 3'h1
`define PTS_LIM_T0 3'h2
`define PTS_LIM_T1 3'h3
`define PTS_LIM_SD 3'h4
`define PTS_LIM_L0 3'h5
// register addresses
`define PTS_A_CTRL 5'h00
`define PTS_A_C0LIM 5'h01
`define PTS_A_C1LIM 5'h02
`define PTS_A_L0 5'h06
`define PTS_A_ADJ 5'h07
`define PTS_A_HOLD 5'h08
`define PTS_A_BTE_LO 5'h09
`define PTS_A_BTE_HI 5'h0A
`define PTS_A_ADCSEL 5'h0B
// control register bits
`define PTS_CTRL_EN 0
`define PTS_CTRL_START 1
`define PTS_CTRL_SWT 2
`define PTS_CTRL_SDEN 3
`define PTS_CTRL_ST 4
// reset values
`define PTS_RST16 16'h0000
`define PTS_RST32 32'h0000_0000
`endif

// >>> inc/pts_pkg.sv
package pts_pkg;
   typedef enum logic [1:0] {
      pts_st_idle = 2'b00,
      pts_st_wait_t = 2'b01,
      pts_st_wait_sw = 2'b11
   } pts_state_t;

   typedef struct packed {
      logic [3:0] cmd;
      logic [3:0] opt;
   } pts_step_t;

   typedef struct packed {
      logic [4:0] addr;
      logic [15:0] wdata;
      logic we;
      logic re;
   } pts_bus_t;

   // six limit slots, indexed by destination code
   typedef logic [5:0][15:0] pts_lim_t;

   typedef struct packed {
      logic [1:0] pin_select_routing;
      logic [1:0] cmp_mask;
      logic [1:0] pwm_sync;
      logic [3:0] adc_trig;
      logic [3:0] ic_sync;
      logic [3:0] oc_clk;
      logic [3:0] oc_sync;
   } pts_trig_t;
endpackage

// >>> src/pts_sequencer.sv
`include "pts_cfg.svh"
module pts_sequencer (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // register port
   input wire pts_pkg::pts_bus_t bus_i,
   output logic [15:0] rdata_o,
   // step command stream
   input wire pts_pkg::pts_step_t step_i,
   input wire logic step_valid_i,
   output logic step_ready_o,
   // loop counter values
   input wire logic [15:0] cnt0_i,
   input wire logic [15:0] cnt1_i,
   // to peripherals and sibling units
   output pts_pkg::pts_trig_t trig_o,
   output logic [15:0] adc_sel_o,
   output pts_pkg::pts_lim_t lim_o,
   output logic sd_en_o
);
   import pts_pkg::*;

   pts_state_t state_q, state_d;
   pts_lim_t lim_q;
   pts_trig_t trig_q;
   logic [15:0] adj_q, hold_q, adc_q, tmr_q, rdata_q, tmr_lim;
   logic [31:0] bte_q;
   logic en_q, en_d, start_q, start_d, swt_q, swt_prev_q, sd_en_q, tsel_q, ready_q;
   logic run, run_d, accept, is_ctrl, is_addcopy, ctrl_wr, swt_rise, bcast_go;
   logic [2:0] wr_idx;

   function automatic pts_lim_t lim_update(pts_lim_t cur, logic [3:0] opt,
                                           logic [15:0] adj, logic [15:0] hold);
      pts_lim_t r;
      r = cur;
      if (opt[2:0] <= `PTS_LIM_L0)
      begin
         if (opt[3])
            r[opt[2:0]] = hold;
         else
            r[opt[2:0]] = 16'(cur[opt[2:0]] + adj);
      end
      return r;
   endfunction

   assign run = en_q & start_q;
   assign accept = step_valid_i & ready_q;
   assign is_ctrl = accept && (step_i.cmd == `PTS_CMD_CTRL);
   assign is_addcopy = accept && (step_i.cmd == `PTS_CMD_ADDCOPY);
   assign bcast_go = is_ctrl && (step_i.opt == `PTS_OPT_BCAST);
   assign ctrl_wr = bus_i.we && (bus_i.addr == `PTS_A_CTRL);
   assign en_d = ctrl_wr ? bus_i.wdata[`PTS_CTRL_EN] : en_q;
   assign start_d = ctrl_wr ? bus_i.wdata[`PTS_CTRL_START] : start_q;
   assign run_d = en_d & start_d;
   assign swt_rise = swt_q & ~swt_prev_q;
   assign tmr_lim = tsel_q ? lim_q[`PTS_LIM_T1] : lim_q[`PTS_LIM_T0];
   assign wr_idx = 3'(bus_i.addr - `PTS_A_C0LIM);

   assign rdata_o = rdata_q;
   assign step_ready_o = ready_q;
   assign trig_o = trig_q;
   assign adc_sel_o = adc_q;
   assign lim_o = lim_q;
   assign sd_en_o = sd_en_q;

   // step sequencing
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         pts_st_idle:
         begin
            if (is_ctrl && (step_i.opt == `PTS_OPT_WAIT_T0 ||
                            step_i.opt == `PTS_OPT_WAIT_T1))
               state_d = pts_st_wait_t;
            else if (is_ctrl && step_i.opt == `PTS_OPT_WAIT_SW)
               state_d = pts_st_wait_sw;
         end
         pts_st_wait_t:
         begin
            if (!run || tmr_q == tmr_lim)
               state_d = pts_st_idle;
         end
         pts_st_wait_sw:
         begin
            if (!run || swt_rise)
               state_d = pts_st_idle;
         end
         default:
            state_d = pts_st_idle;
      endcase
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
         state_q <= pts_st_idle;
      else
         state_q <= state_d;
   end

   // next step only taken once back in idle
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
         ready_q <= 1'b0;
      else
         ready_q <= (state_d == pts_st_idle) && run_d;
   end

   // wait timers
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         tsel_q <= 1'b0;
         tmr_q <= `PTS_RST16;
      end
      else
      begin
         if (is_ctrl && (step_i.opt == `PTS_OPT_WAIT_T0 ||
                         step_i.opt == `PTS_OPT_WAIT_T1))
            tsel_q <= step_i.opt[0];
         if (state_q == pts_st_wait_t && state_d == pts_st_wait_t)
            tmr_q <= 16'(tmr_q + 16'h0001);
         else
            tmr_q <= `PTS_RST16;
      end
   end

   // control bits
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         en_q <= 1'b0;
         start_q <= 1'b0;
         swt_q <= 1'b0;
         swt_prev_q <= 1'b0;
      end
      else
      begin
         en_q <= en_d;
         start_q <= start_d;
         swt_prev_q <= swt_q;
         if (ctrl_wr)
            swt_q <= bus_i.wdata[`PTS_CTRL_SWT];
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
         sd_en_q <= 1'b0;
      else if (is_ctrl && step_i.opt == `PTS_OPT_SD_OFF)
         sd_en_q <= 1'b0;
      else if (is_ctrl && step_i.opt == `PTS_OPT_SD_ON)
         sd_en_q <= 1'b1;
   end

   // limit slots: a step outranks a software write in the same cycle
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
         lim_q <= '0;
      else if (is_addcopy)
         lim_q <= lim_update(lim_q, step_i.opt, adj_q, hold_q);
      else if (bus_i.we && bus_i.addr >= `PTS_A_C0LIM && bus_i.addr <= `PTS_A_L0 &&
               !(bus_i.addr == `PTS_A_C1LIM && run))
         lim_q[wr_idx] <= bus_i.wdata;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
         hold_q <= `PTS_RST16;
      else if (bus_i.we && bus_i.addr == `PTS_A_HOLD && !run)
         hold_q <= bus_i.wdata;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         adj_q <= `PTS_RST16;
         bte_q <= `PTS_RST32;
      end
      else if (bus_i.we)
      begin
         if (bus_i.addr == `PTS_A_ADJ)
            adj_q <= bus_i.wdata;
         if (bus_i.addr == `PTS_A_BTE_LO)
            bte_q[15:0] <= bus_i.wdata;
         if (bus_i.addr == `PTS_A_BTE_HI)
            bte_q[31:16] <= bus_i.wdata;
      end
   end

   // ADC channel select
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
         adc_q <= `PTS_RST16;
      else if (is_ctrl)
      begin
         case (step_i.opt)
            `PTS_OPT_ADC_C0: adc_q <= cnt0_i;
            `PTS_OPT_ADC_C1: adc_q <= cnt1_i;
            `PTS_OPT_ADC_L0: adc_q <= lim_q[`PTS_LIM_L0];
            default: adc_q <= adc_q;
         endcase
      end
   end

   // one-cycle broadcast pulses; reserved outputs 20..29 are not carried
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i || !bcast_go)
         trig_q <= '0;
      else
      begin
         trig_q.oc_sync <= bte_q[3:0];
         trig_q.oc_clk <= bte_q[7:4];
         trig_q.ic_sync <= bte_q[11:8];
         trig_q.adc_trig <= bte_q[15:12];
         trig_q.pwm_sync <= bte_q[17:16];
         trig_q.cmp_mask <= bte_q[19:18];
         trig_q.pin_select_routing <= bte_q[31:30];
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i || !bus_i.re)
         rdata_q <= `PTS_RST16;
      else
      begin
         rdata_q <= `PTS_RST16;
         case (bus_i.addr)
            `PTS_A_CTRL:
            begin
               rdata_q[`PTS_CTRL_EN] <= en_q;
               rdata_q[`PTS_CTRL_START] <= start_q;
               rdata_q[`PTS_CTRL_SWT] <= swt_q;
               rdata_q[`PTS_CTRL_SDEN] <= sd_en_q;
               rdata_q[`PTS_CTRL_ST +: 2] <= state_q;
            end
            `PTS_A_ADJ: rdata_q <= adj_q;
            `PTS_A_HOLD: rdata_q <= hold_q;
            `PTS_A_BTE_LO: rdata_q <= bte_q[15:0];
            `PTS_A_BTE_HI: rdata_q <= bte_q[31:16];
            `PTS_A_ADCSEL: rdata_q <= adc_q;
            default:
            begin
               if (bus_i.addr >= `PTS_A_C0LIM && bus_i.addr <= `PTS_A_L0)
                  rdata_q <= lim_q[wr_idx];
            end
         endcase
      end
   end

   // checks
   property p_c1lim_wr;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      !run && bus_i.we && bus_i.addr == `PTS_A_C1LIM |=> lim_q[1] == $past(bus_i.wdata);
   endproperty
   a_c1lim_wr: assert property (p_c1lim_wr) else $error("counter1 limit write lost");

   property p_hold_wr;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      !run && bus_i.we && bus_i.addr == `PTS_A_HOLD |=> hold_q == $past(bus_i.wdata);
   endproperty
   a_hold_wr: assert property (p_hold_wr) else $error("hold write lost");

   property p_lock;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      run && bus_i.we && !is_addcopy |=> $stable(hold_q) && $stable(lim_q[1]);
   endproperty
   a_lock: assert property (p_lock) else $error("locked register changed");

   property p_sd;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      is_ctrl && (step_i.opt == `PTS_OPT_SD_ON || step_i.opt == `PTS_OPT_SD_OFF)
      |=> sd_en_o == ($past(step_i.opt) == `PTS_OPT_SD_ON);
   endproperty
   a_sd: assert property (p_sd) else $error("step delay enable wrong");

   property p_wait_t;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      is_ctrl && step_i.opt == `PTS_OPT_WAIT_T0 && lim_q[2] == 16'h0003 && !bus_i.we
      ##1 (run && !bus_i.we)[*4] |-> !$past(step_ready_o, 3) && !$past(step_ready_o, 2) &&
      !$past(step_ready_o) && !step_ready_o ##1 step_ready_o;
   endproperty
   a_wait_t: assert property (p_wait_t) else $error("timer wait length wrong");

   property p_wait_sw;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      state_q == pts_st_wait_sw && run && !swt_rise |=> state_q == pts_st_wait_sw;
   endproperty
   a_wait_sw: assert property (p_wait_sw) else $error("left software wait early");

   property p_adc;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      is_ctrl && step_i.opt == `PTS_OPT_ADC_C1 |=> adc_sel_o == $past(cnt1_i);
   endproperty
   a_adc: assert property (p_adc) else $error("adc select not loaded");

   property p_bcast;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      bcast_go |=> trig_o == {$past(bte_q[31:30]), $past(bte_q[19:0])};
   endproperty
   a_bcast: assert property (p_bcast)
      else $error("broadcast map wrong");

   property p_pulse;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      trig_o != '0 |-> $past(bcast_go);
   endproperty
   a_pulse: assert property (p_pulse) else $error("trigger without broadcast");

   property p_add;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      is_addcopy && step_i.opt == 4'h0 |=> lim_q[0] == 16'($past(lim_q[0]) + $past(adj_q));
   endproperty
   a_add: assert property (p_add) else $error("add result wrong");

   property p_copy;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      is_addcopy && step_i.opt == 4'hD |=> lim_q[5] == $past(hold_q);
   endproperty
   a_copy: assert property (p_copy) else $error("copy result wrong");

   property p_nop;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      accept && !bus_i.we && (step_i.opt == 4'h7 || step_i.opt == 4'hE) &&
      step_i.cmd == `PTS_CMD_ADDCOPY |=> $stable(lim_q) && $stable(adc_q) && $stable(sd_en_q);
   endproperty
   a_nop: assert property (p_nop) else $error("reserved option had effect");

   property p_order;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      state_q != pts_st_idle |-> !step_ready_o;
   endproperty
   a_order: assert property (p_order) else $error("step taken during wait");

   c_wait_t: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      state_q == pts_st_wait_t ##1 state_q == pts_st_idle);
   c_wait_sw: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      state_q == pts_st_wait_sw && swt_rise);
   c_bcast: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      trig_o.adc_trig != 4'h0);
   c_copy: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      is_addcopy && step_i.opt[3]);
endmodule

// >>> verification/pts_periph_model.sv
// peripheral side: loop counter values out, trigger pulses collected
module pts_periph_model
   import pts_pkg::*;
#(
   parameter logic [15:0] CNT0_VAL = 16'h0123,
   parameter logic [15:0] CNT1_VAL = 16'h0456
)
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // from sequencer and bench
   input wire pts_pkg::pts_trig_t trig_i,
   input wire logic seen_clr_i,
   // to sequencer and bench
   output logic [15:0] cnt0_o,
   output logic [15:0] cnt1_o,
   output pts_pkg::pts_trig_t seen_o
);
   timeunit 1ns;
   timeprecision 100ps;
   assign cnt0_o = CNT0_VAL;
   assign cnt1_o = CNT1_VAL;
   // sticky record of every pulse per destination
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i || seen_clr_i)
         seen_o <= '0;
      else
         seen_o <= seen_o | trig_i;
   end
endmodule

// >>> verification/tb_pts_sequencer.sv
`include "pts_cfg.svh"
module tb_pts_sequencer;
   timeunit 1ns;
   timeprecision 100ps;
   import pts_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   pts_bus_t bus_i = '0;
   pts_step_t step_i = '0;
   logic step_valid_i = 1'b0;
   logic seen_clr = 1'b0;
   logic [15:0] rdata_o, adc_sel_o, cnt0, cnt1;
   logic step_ready_o, sd_en_o;
   pts_trig_t trig_o, seen;
   pts_lim_t lim_o;
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int n;
   always #2 clk_sys_i = ~clk_sys_i;
   pts_sequencer dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .bus_i(bus_i),
      .rdata_o(rdata_o), .step_i(step_i), .step_valid_i(step_valid_i),
      .step_ready_o(step_ready_o), .cnt0_i(cnt0), .cnt1_i(cnt1), .trig_o(trig_o),
      .adc_sel_o(adc_sel_o), .lim_o(lim_o), .sd_en_o(sd_en_o));
   pts_periph_model model (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .trig_i(trig_o),
      .seen_clr_i(seen_clr), .cnt0_o(cnt0), .cnt1_o(cnt1), .seen_o(seen));
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [95:0] seen_v, input logic [95:0] exp_v, input string msg);
      tests_run++;
      if (seen_v !== exp_v)
      begin
         num_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, seen_v, exp_v);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      bus_i <= {a, d, 1'b1, 1'b0};
      @(posedge clk_sys_i);
      bus_i <= '0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge clk_sys_i);
      bus_i <= {a, 16'h0000, 1'b0, 1'b1};
      @(posedge clk_sys_i);
      bus_i <= '0;
      #1 check(rdata_o, e, "read data");
   endtask
   // offer a step and return at the edge that takes it
   task automatic step(input logic [3:0] c, input logic [3:0] o);
      int k;
      k = 0;
      @(posedge clk_sys_i);
      step_i <= {c, o};
      step_valid_i <= 1'b1;
      do
      begin
         @(posedge clk_sys_i);
         k++;
      end
      while (step_ready_o !== 1'b1 && k < 100);
      step_valid_i <= 1'b0;
      check(k < 100, 1, "step not taken");
   endtask
   task automatic t_regs();
      check(lim_o, '0, "limits after reset");
      rd(`PTS_A_C1LIM, `PTS_RST16);
      rd(`PTS_A_HOLD, `PTS_RST16);
      wr(`PTS_A_C1LIM, 16'h00AB);
      wr(`PTS_A_HOLD, 16'h1000);
      wr(5'h1F, 16'hFFFF);
      rd(`PTS_A_C1LIM, 16'h00AB);
      rd(`PTS_A_HOLD, 16'h1000);
      rd(5'h1F, 16'h0000);
      wr(`PTS_A_CTRL, 16'h0003);
      wr(`PTS_A_C1LIM, 16'h5555);
      wr(`PTS_A_HOLD, 16'h5555);
      rd(`PTS_A_C1LIM, 16'h00AB);
      rd(`PTS_A_HOLD, 16'h1000);
      check(lim_o[1], 16'h00AB, "counter1 limit locked");
      $display("test regs done");
   endtask
   task automatic t_timer(input logic [3:0] o, input logic [4:0] a, input logic [15:0] l);
      wr(a, l);
      step(`PTS_CMD_CTRL, o);
      n = 0;
      #1;
      while (step_ready_o !== 1'b1 && n < 50)
      begin
         n++;
         @(posedge clk_sys_i);
         #1;
      end
      check(n, l + 1, "timer wait length");
      $display("test timer wait done");
   endtask
   task automatic t_sw();
      step(`PTS_CMD_CTRL, `PTS_OPT_WAIT_SW);
      repeat (6) @(posedge clk_sys_i);
      #1 check(step_ready_o, 0, "held in software wait");
      wr(`PTS_A_CTRL, 16'h0007);
      n = 0;
      while (step_ready_o !== 1'b1 && n < 5)
      begin
         n++;
         @(posedge clk_sys_i);
         #1;
      end
      check(step_ready_o, 1, "software wait released");
      wr(`PTS_A_CTRL, 16'h0003);
      $display("test software wait done");
   endtask
   task automatic t_misc();
      step(`PTS_CMD_CTRL, `PTS_OPT_SD_ON);
      #1 check(sd_en_o, 1, "step delay on");
      step(`PTS_CMD_CTRL, `PTS_OPT_SD_OFF);
      #1 check(sd_en_o, 0, "step delay off");
      wr(`PTS_A_L0, 16'h0789);
      step(`PTS_CMD_CTRL, `PTS_OPT_ADC_C0);
      #1 check(adc_sel_o, 16'h0123, "adc from counter0");
      step(`PTS_CMD_CTRL, `PTS_OPT_ADC_C1);
      #1 check(adc_sel_o, 16'h0456, "adc from counter1");
      step(`PTS_CMD_CTRL, `PTS_OPT_ADC_L0);
      #1 check(adc_sel_o, 16'h0789, "adc from literal0");
      rd(`PTS_A_ADCSEL, 16'h0789);
      wr(`PTS_A_BTE_LO, 16'hA5C3);
      wr(`PTS_A_BTE_HI, 16'hFFFA);
      seen_clr <= 1'b1;
      @(posedge clk_sys_i);
      seen_clr <= 1'b0;
      step(`PTS_CMD_CTRL, `PTS_OPT_BCAST);
      #1 check(trig_o, {2'b11, 4'hA, 16'hA5C3}, "broadcast pulse");
      @(posedge clk_sys_i);
      #1 check(trig_o, 0, "pulse one cycle");
      check(seen, {2'b11, 4'hA, 16'hA5C3}, "destinations");
      check(seen.oc_sync, 4'h3, "compare sync outputs");
      check(seen.oc_clk, 4'hC, "compare clock outputs");
      check(seen.ic_sync, 4'h5, "capture sync outputs");
      check(seen.adc_trig, 4'hA, "adc sample outputs");
      check(seen.pwm_sync, 2'b10, "pwm sync outputs");
      check(seen.cmp_mask, 2'b10, "comparator mask outputs");
      check(seen.pin_select_routing, 2'b11, "pin select outputs");
      $display("test control options done");
   endtask
   task automatic t_addcopy();
      logic [3:0] rsv [7];
      pts_lim_t keep;
      rsv = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h7, 4'hA};
      wr(`PTS_A_ADJ, 16'h0010);
      for (int i = 0; i < 6; i++)
      begin
         step(`PTS_CMD_ADDCOPY, 4'h8 + i[3:0]);
         #1 check(lim_o[i], 16'h1000, "copy hold");
      end
      for (int i = 0; i < 6; i++)
      begin
         step(`PTS_CMD_ADDCOPY, i[3:0]);
         #1 check(lim_o[i], 16'h1010, "add adjust");
      end
      rd(`PTS_A_C1LIM, 16'h1010);
      keep = lim_o;
      for (int i = 0; i < 4; i++)
      begin
         step(`PTS_CMD_ADDCOPY, (i < 2) ? 4'h6 + i[3:0] : 4'hC + i[3:0]);
         #1 check(lim_o, keep, "reserved add or copy");
      end
      for (int i = 0; i < 7; i++)
      begin
         step(`PTS_CMD_CTRL, rsv[i]);
         #1 check(trig_o, 0, "reserved control");
      end
      for (int c = 2; c < 16; c++)
      begin
         step(c[3:0], `PTS_OPT_BCAST);
         #1 check(trig_o, 0, "reserved command");
      end
      check(lim_o, keep, "limits untouched");
      check({sd_en_o, adc_sel_o}, {1'b0, 16'h0789}, "state untouched");
      $display("test add copy reserved done");
   endtask
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         results();
      end
   end
   initial
   begin
      repeat (8) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      @(posedge clk_sys_i);
      #1;
      t_regs();
      t_timer(`PTS_OPT_WAIT_T0, 5'h03, 16'h0003);
      t_timer(`PTS_OPT_WAIT_T1, 5'h04, 16'h0002);
      t_sw();
      t_misc();
      t_addcopy();
      results();
   end
endmodule
